// ==== logic/mqps_device.sv ====
// Summary of operation
// - Capture write queue on strobed clock edge
// - Write enable ignored for write selection
// - Last write selection stays until replaced
// - Data accepted every edge, selection edge too
// - Controller spaces write selections three cycles
// - Full flag follows new queue next edge
// - Second edge onward writes go new queue
// - Selection edge and next write old queue
// - Full queue never written
// - Write address: two queue, three device bits
// - Selection honoured only on identity match
// - Full flag bus owner chosen by strobe
// - Capture read queue on strobed edge, unless empty flag bus strobe also high
// - Controller spaces read selections three cycles
// - New queue word lands third edge after
// - Old queue read at selection, forced next
// - Output enable only gates data drive
// - Old last, new first delivered back to back
// - Empty new queue: hold word, valid off
// - Read address: two queue, three device bits
// - Empty flag bus owner chosen by strobe
// - Null select picks always-empty queue
`timescale 1ns/1ps
`default_nettype none
module mqps_device (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic deviceIdentityBit0,
  input wire logic deviceIdentityBit1,
  input wire logic deviceIdentityBit2,
  mqps_if.dev link
);
  import mqps_pkg::*;

  mqps_id_t idSync1_r;
  mqps_id_t idSync2_r;
  mqps_word_t mem [NUM_Q][QDEPTH];
  logic [PTR_W-1:0] wrPtr_r [NUM_Q];
  logic [PTR_W-1:0] rdPtr_r [NUM_Q];
  mqps_cnt_t count_r [NUM_Q];
  mqps_cnt_t cntNxt [NUM_Q];

  mqps_qsel_t wrQ_r;
  mqps_qsel_t wrNewQ_r;
  logic wrOwn_r;
  logic wrNewOwn_r;
  logic wrPend_r;
  logic activeFull_n_r;
  logic activeFullEn_r;
  logic afOwn_r;
  mqps_flags_t almostFull_r;

  mqps_qsel_t rdQ_r;
  mqps_qsel_t rdNewQ_r;
  logic rdOwn_r;
  logic rdNewOwn_r;
  logic rdNull_r;
  logic rdNewNull_r;
  typedef enum logic [PHASE_W-1:0] {RD_IDLE, RD_SWAP, RD_FILL, RD_LAND} mqps_rd_phase_t;
  mqps_rd_phase_t rdPhase_r;
  mqps_word_t pipe_r;
  logic pipeValid_r;
  mqps_word_t dataOut_r;
  logic outputValid_n_r;
  logic dataOutEn_r;
  logic aeOwn_r;
  mqps_flags_t almostEmpty_r;

  // Identity pins are static but external, so synchronise them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idSync1_r <= ID_ZERO;
      idSync2_r <= ID_ZERO;
    end else begin
      idSync1_r <= {deviceIdentityBit2, deviceIdentityBit1, deviceIdentityBit0};
      idSync2_r <= idSync1_r;
    end
  end

  // Write side decode
  wire mqps_id_t wrDevField = link.writeQueueAddress[QADDR_W-1:QSEL_W];
  wire mqps_qsel_t wrQField = link.writeQueueAddress[QSEL_W-1:0];
  wire logic wrIdMatch = (wrDevField == idSync2_r);
  wire logic wrSelEvent = link.writeAddressStrobe;
  wire logic afSelEvent = link.almostFullBusStrobe && !link.writeAddressStrobe;
  wire logic wrTargetFull = (count_r[wrQ_r] == CNT_FULL);
  wire logic wrDo = wrOwn_r && !link.writeEnable_n && !wrTargetFull;
  wire mqps_qsel_t flagQ = wrPend_r ? wrNewQ_r : wrQ_r;
  wire logic flagOwn = wrPend_r ? wrNewOwn_r : wrOwn_r;

  // Read side decode
  wire mqps_id_t rdDevField = link.readQueueAddress[QADDR_W-1:QSEL_W];
  wire mqps_qsel_t rdQField = link.readQueueAddress[QSEL_W-1:0];
  wire logic rdIdMatch = (rdDevField == idSync2_r);
  wire logic rdSelEvent = link.readAddressStrobe && !link.almostEmptyBusStrobe;
  wire logic aeSelEvent = link.almostEmptyBusStrobe && !link.readAddressStrobe;
  wire logic srcEmpty = rdNull_r || !rdOwn_r || (count_r[rdQ_r] == CNT_EMPTY);
  wire logic forceAdv = (rdPhase_r != RD_IDLE);
  wire logic advance = pipeValid_r && (outputValid_n_r || !link.readEnable_n || forceAdv);
  wire logic pipeFree = !pipeValid_r || advance;
  wire logic pop = !srcEmpty && pipeFree;
  wire logic rdConsume = !link.readEnable_n || (rdPhase_r == RD_LAND);

  // Queue occupancy after this edge
  always_comb begin
    for (int q = 0; q < NUM_Q; q++) begin
      cntNxt[q] = count_r[q];
      if (wrDo && (wrQ_r == q[QSEL_W-1:0])) begin
        cntNxt[q] = cntNxt[q] + CNT_ONE;
      end
      if (pop && (rdQ_r == q[QSEL_W-1:0])) begin
        cntNxt[q] = cntNxt[q] - CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int q = 0; q < NUM_Q; q++) begin
        wrPtr_r[q] <= PTR_ZERO;
        rdPtr_r[q] <= PTR_ZERO;
        count_r[q] <= CNT_EMPTY;
      end
    end else begin
      for (int q = 0; q < NUM_Q; q++) begin
        count_r[q] <= cntNxt[q];
      end
      if (wrDo) begin
        wrPtr_r[wrQ_r] <= wrPtr_r[wrQ_r] + PTR_ONE;
      end
      if (pop) begin
        rdPtr_r[rdQ_r] <= rdPtr_r[rdQ_r] + PTR_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (wrDo) begin
      mem[wrQ_r][wrPtr_r[wrQ_r]] <= link.dataIn;
    end
  end

  // Write queue selection, applied one edge after capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrQ_r <= QSEL_ZERO;
      wrNewQ_r <= QSEL_ZERO;
      wrOwn_r <= 1'b0;
      wrNewOwn_r <= 1'b0;
      wrPend_r <= 1'b0;
    end else if (wrSelEvent) begin
      wrPend_r <= 1'b1;
      wrNewOwn_r <= wrIdMatch;
      if (wrIdMatch) begin
        wrNewQ_r <= wrQField;
      end
    end else if (wrPend_r) begin
      wrPend_r <= 1'b0;
      wrQ_r <= wrNewQ_r;
      wrOwn_r <= wrNewOwn_r;
    end
  end

  // Active full flag and almost-full flag bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      activeFull_n_r <= 1'b1;
      activeFullEn_r <= 1'b0;
      afOwn_r <= 1'b0;
      almostFull_r <= '0;
    end else begin
      activeFull_n_r <= (cntNxt[flagQ] != CNT_FULL);
      activeFullEn_r <= flagOwn;
      if (afSelEvent) begin
        afOwn_r <= wrIdMatch;
      end
      for (int q = 0; q < NUM_Q; q++) begin
        almostFull_r[q] <= (cntNxt[q] >= AF_LEVEL);
      end
    end
  end

  // Read queue selection and switch sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdQ_r <= QSEL_ZERO;
      rdNewQ_r <= QSEL_ZERO;
      rdOwn_r <= 1'b0;
      rdNewOwn_r <= 1'b0;
      rdNull_r <= 1'b1;
      rdNewNull_r <= 1'b1;
      rdPhase_r <= RD_IDLE;
    end else if (rdSelEvent) begin
      rdPhase_r <= RD_SWAP;
      rdNewNull_r <= link.nullSelect;
      rdNewOwn_r <= link.nullSelect || rdIdMatch;
      if (rdIdMatch && !link.nullSelect) begin
        rdNewQ_r <= rdQField;
      end
    end else begin
      unique case (rdPhase_r)
        RD_SWAP: begin
          rdPhase_r <= RD_FILL;
          rdQ_r <= rdNewQ_r;
          rdOwn_r <= rdNewOwn_r;
          rdNull_r <= rdNewNull_r;
        end
        RD_FILL: rdPhase_r <= RD_LAND;
        RD_LAND: rdPhase_r <= RD_IDLE;
        RD_IDLE: rdPhase_r <= RD_IDLE;
      endcase
    end
  end

  // Fall-through pipeline and output register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_r <= '0;
      pipeValid_r <= 1'b0;
      dataOut_r <= '0;
      outputValid_n_r <= 1'b1;
    end else begin
      if (pop) begin
        pipe_r <= mem[rdQ_r][rdPtr_r[rdQ_r]];
        pipeValid_r <= 1'b1;
      end else if (advance) begin
        pipeValid_r <= 1'b0;
      end
      if (advance) begin
        dataOut_r <= pipe_r;
        outputValid_n_r <= 1'b0;
      end else if (rdConsume) begin
        outputValid_n_r <= 1'b1;
      end
    end
  end

  // Output drive and almost-empty flag bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOutEn_r <= 1'b0;
      aeOwn_r <= 1'b0;
      almostEmpty_r <= '1;
    end else begin
      dataOutEn_r <= !link.outputEnable_n && rdOwn_r;
      if (aeSelEvent) begin
        aeOwn_r <= rdIdMatch;
      end
      for (int q = 0; q < NUM_Q; q++) begin
        almostEmpty_r[q] <= (cntNxt[q] <= AE_LEVEL);
      end
    end
  end

  assign link.dataOut = dataOut_r;
  assign link.dataOutEn = dataOutEn_r;
  assign link.outputValid_n = outputValid_n_r;
  assign link.activeFull_n = activeFull_n_r;
  assign link.activeFullEn = activeFullEn_r;
  assign link.almostFullFlag = almostFull_r;
  assign link.almostFullEn = afOwn_r;
  assign link.almostEmptyFlag = almostEmpty_r;
  assign link.almostEmptyEn = aeOwn_r;
endmodule : mqps_device
`default_nettype wire

// ==== logic/mqps_pkg.sv ====
`default_nettype none
package mqps_pkg;
  localparam int DATA_W = 18;
  localparam int QADDR_W = 5;
  localparam int QSEL_W = 2;
  localparam int ID_W = 3;
  localparam int NUM_Q = 4;
  localparam int QDEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int PHASE_W = 2;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [CNT_W-1:0] CNT_EMPTY = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] AF_LEVEL = 4'h6;
  localparam logic [CNT_W-1:0] AE_LEVEL = 4'h2;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [PTR_W-1:0] PTR_ZERO = 3'h0;
  localparam logic [PHASE_W-1:0] SEL_GAP = 2'h3;
  localparam logic [PHASE_W-1:0] GAP_ONE = 2'h1;
  localparam logic [PHASE_W-1:0] GAP_ZERO = 2'h0;
  localparam logic [QSEL_W-1:0] QSEL_ZERO = 2'h0;
  localparam logic [ID_W-1:0] ID_ZERO = 3'h0;
  typedef logic [DATA_W-1:0] mqps_word_t;
  typedef logic [QADDR_W-1:0] mqps_addr_t;
  typedef logic [QSEL_W-1:0] mqps_qsel_t;
  typedef logic [ID_W-1:0] mqps_id_t;
  typedef logic [NUM_Q-1:0] mqps_flags_t;
  typedef logic [CNT_W-1:0] mqps_cnt_t;
endpackage : mqps_pkg
`default_nettype wire

// ==== logic/mqps_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mqps_if;
  import mqps_pkg::*;
  mqps_word_t dataIn;
  logic writeEnable_n;
  mqps_addr_t writeQueueAddress;
  logic writeAddressStrobe;
  logic almostFullBusStrobe;
  mqps_addr_t readQueueAddress;
  logic readAddressStrobe;
  logic almostEmptyBusStrobe;
  logic nullSelect;
  logic readEnable_n;
  logic outputEnable_n;
  mqps_word_t dataOut;
  logic dataOutEn;
  logic outputValid_n;
  logic activeFull_n;
  logic activeFullEn;
  mqps_flags_t almostFullFlag;
  logic almostFullEn;
  mqps_flags_t almostEmptyFlag;
  logic almostEmptyEn;
  // Bus levels when undriven: data low, full and flags pulled inactive
  mqps_word_t dataBus;
  logic activeFullBus_n;
  mqps_flags_t almostFullBus;
  mqps_flags_t almostEmptyBus;
  assign dataBus = dataOutEn ? dataOut : '0;
  assign activeFullBus_n = activeFullEn ? activeFull_n : 1'b1;
  assign almostFullBus = almostFullEn ? almostFullFlag : '0;
  assign almostEmptyBus = almostEmptyEn ? almostEmptyFlag : '0;
  modport dev (
    input dataIn, writeEnable_n, writeQueueAddress, writeAddressStrobe, almostFullBusStrobe,
    input readQueueAddress, readAddressStrobe, almostEmptyBusStrobe, nullSelect,
    input readEnable_n, outputEnable_n,
    output dataOut, dataOutEn, outputValid_n, activeFull_n, activeFullEn,
    output almostFullFlag, almostFullEn, almostEmptyFlag, almostEmptyEn
  );
  modport host (
    output dataIn, writeEnable_n, writeQueueAddress, writeAddressStrobe, almostFullBusStrobe,
    output readQueueAddress, readAddressStrobe, almostEmptyBusStrobe, nullSelect,
    output readEnable_n, outputEnable_n,
    input dataBus, outputValid_n, activeFullBus_n, almostFullBus, almostEmptyBus
  );
endinterface : mqps_if
`default_nettype wire

// ==== logic/mqps_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module mqps_host (
  input wire logic clk,
  input wire logic rst_n,
  mqps_if.host link,
  input wire logic userWrSelect,
  input wire mqps_pkg::mqps_addr_t userWrSelAddr,
  input wire logic userWrValid,
  input wire mqps_pkg::mqps_word_t userWrData,
  input wire logic userAfSelect,
  input wire logic userRdSelect,
  input wire mqps_pkg::mqps_addr_t userRdSelAddr,
  input wire logic userRdNull,
  input wire logic userAeSelect,
  input wire mqps_pkg::mqps_id_t userFlagDevice,
  input wire logic userRdTake,
  input wire logic userOutEnable,
  output logic userWrSelReady,
  output logic userRdSelReady,
  output mqps_pkg::mqps_word_t userRdData,
  output logic userRdDataValid,
  output logic userFull,
  output mqps_pkg::mqps_flags_t userAlmostFull,
  output mqps_pkg::mqps_flags_t userAlmostEmpty
);
  import mqps_pkg::*;

  logic [PHASE_W-1:0] wrGap_r;
  logic [PHASE_W-1:0] rdGap_r;
  mqps_word_t dataIn_r;
  logic writeEnable_n_r;
  mqps_addr_t wrAddr_r;
  logic wrStrobe_r;
  logic afStrobe_r;
  mqps_addr_t rdAddr_r;
  logic rdStrobe_r;
  logic aeStrobe_r;
  logic nullSel_r;
  logic readEnable_n_r;
  logic outputEnable_n_r;

  wire logic wrGo = userWrSelect && (wrGap_r == GAP_ZERO);
  wire logic rdGo = userRdSelect && (rdGap_r == GAP_ZERO);
  wire logic afGo = userAfSelect && !wrGo;
  wire logic aeGo = userAeSelect && !rdGo;
  wire mqps_addr_t flagAddr = {userFlagDevice, QSEL_ZERO};
  wire mqps_addr_t wrAddrNxt = wrGo ? userWrSelAddr : flagAddr;
  wire mqps_addr_t rdAddrNxt = rdGo ? userRdSelAddr : flagAddr;
  wire logic wordTaken = !link.outputValid_n && (!readEnable_n_r || rdGap_r != GAP_ZERO);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrGap_r <= GAP_ZERO;
      rdGap_r <= GAP_ZERO;
    end else begin
      if (wrGo) begin
        wrGap_r <= SEL_GAP;
      end else if (wrGap_r != GAP_ZERO) begin
        wrGap_r <= wrGap_r - GAP_ONE;
      end
      if (rdGo) begin
        rdGap_r <= SEL_GAP;
      end else if (rdGap_r != GAP_ZERO) begin
        rdGap_r <= rdGap_r - GAP_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataIn_r <= '0;
      writeEnable_n_r <= 1'b1;
      wrAddr_r <= '0;
      wrStrobe_r <= 1'b0;
      afStrobe_r <= 1'b0;
      rdAddr_r <= '0;
      rdStrobe_r <= 1'b0;
      aeStrobe_r <= 1'b0;
      nullSel_r <= 1'b0;
      readEnable_n_r <= 1'b1;
      outputEnable_n_r <= 1'b1;
    end else begin
      dataIn_r <= userWrData;
      writeEnable_n_r <= !userWrValid;
      wrAddr_r <= wrAddrNxt;
      wrStrobe_r <= wrGo;
      afStrobe_r <= afGo;
      rdAddr_r <= rdAddrNxt;
      rdStrobe_r <= rdGo;
      aeStrobe_r <= aeGo;
      nullSel_r <= rdGo && userRdNull;
      readEnable_n_r <= !userRdTake;
      outputEnable_n_r <= !userOutEnable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      userWrSelReady <= 1'b0;
      userRdSelReady <= 1'b0;
      userRdData <= '0;
      userRdDataValid <= 1'b0;
      userFull <= 1'b0;
      userAlmostFull <= '0;
      userAlmostEmpty <= '0;
    end else begin
      userWrSelReady <= !wrGo && (wrGap_r <= GAP_ONE);
      userRdSelReady <= !rdGo && (rdGap_r <= GAP_ONE);
      userRdDataValid <= wordTaken;
      if (wordTaken) begin
        userRdData <= link.dataBus;
      end
      userFull <= !link.activeFullBus_n;
      userAlmostFull <= link.almostFullBus;
      userAlmostEmpty <= link.almostEmptyBus;
    end
  end

  assign link.dataIn = dataIn_r;
  assign link.writeEnable_n = writeEnable_n_r;
  assign link.writeQueueAddress = wrAddr_r;
  assign link.writeAddressStrobe = wrStrobe_r;
  assign link.almostFullBusStrobe = afStrobe_r;
  assign link.readQueueAddress = rdAddr_r;
  assign link.readAddressStrobe = rdStrobe_r;
  assign link.almostEmptyBusStrobe = aeStrobe_r;
  assign link.nullSelect = nullSel_r;
  assign link.readEnable_n = readEnable_n_r;
  assign link.outputEnable_n = outputEnable_n_r;
endmodule : mqps_host
`default_nettype wire

// ==== sim/mqps_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module mqps_sva #(
  parameter mqps_pkg::mqps_id_t DEV_ID = 3'h5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire mqps_pkg::mqps_addr_t writeQueueAddress,
  input wire logic writeAddressStrobe,
  input wire logic almostFullBusStrobe,
  input wire mqps_pkg::mqps_addr_t readQueueAddress,
  input wire logic readAddressStrobe,
  input wire logic almostEmptyBusStrobe,
  input wire logic nullSelect,
  input wire logic outputEnable_n,
  input wire logic dataOutEn,
  input wire logic outputValid_n,
  input wire logic activeFullEn,
  input wire logic almostFullEn,
  input wire logic almostEmptyEn
);
  import mqps_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_wsel_gap: assert property (writeAddressStrobe |=> (!writeAddressStrobe) [*2])
    else $error("write selects too close");
  chk_rsel_gap: assert property (readAddressStrobe |=> (!readAddressStrobe) [*2])
    else $error("read selects too close");
  chk_full_owner: assert property (writeAddressStrobe |-> ##2
    (activeFullEn == ($past(writeQueueAddress[QADDR_W-1:QSEL_W], 2) == DEV_ID)))
    else $error("full line owner wrong after write select");
  chk_af_owner: assert property (almostFullBusStrobe && !writeAddressStrobe |-> ##2
    (almostFullEn == ($past(writeQueueAddress[QADDR_W-1:QSEL_W], 2) == DEV_ID)))
    else $error("almost full bus owner wrong");
  chk_ae_owner: assert property (almostEmptyBusStrobe && !readAddressStrobe |-> ##2
    (almostEmptyEn == ($past(readQueueAddress[QADDR_W-1:QSEL_W], 2) == DEV_ID)))
    else $error("almost empty bus owner wrong");
  chk_rd_foreign: assert property (readAddressStrobe && !almostEmptyBusStrobe &&
    !nullSelect && (readQueueAddress[QADDR_W-1:QSEL_W] != DEV_ID) |-> ##3 !dataOutEn)
    else $error("data driven after foreign read select");
  chk_oe_drive: assert property (dataOutEn |-> !$past(outputEnable_n))
    else $error("data driven without output enable");
  chk_null_flush: assert property (readAddressStrobe && nullSelect &&
    !almostEmptyBusStrobe |-> ##4 outputValid_n [*2])
    else $error("output still valid after null select");
endmodule : mqps_sva
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errCount++; \
  $display("ERROR %0t: value mismatch", $time); end end
module tb;
  import mqps_pkg::*;
  localparam mqps_id_t DEV_ID = 3'h5;
  logic clk, rst_n, userWrSelect, userWrValid, userAfSelect, userRdSelect, userRdNull;
  logic userAeSelect, userRdTake, userOutEnable, userWrSelReady, userRdSelReady;
  logic userRdDataValid, userFull, wrOwn;
  mqps_addr_t userWrSelAddr, userRdSelAddr;
  mqps_word_t userWrData, userRdData;
  mqps_id_t userFlagDevice;
  mqps_flags_t userAlmostFull, userAlmostEmpty;
  int errCount, checked, cycles, seed, wrQ;
  mqps_word_t expQ[NUM_Q][$];
  mqps_word_t expStream[$];
  mqps_word_t got[$];

  mqps_if mqps_if_i ();
  mqps_device mqps_device_i (.clk(clk), .rst_n(rst_n), .deviceIdentityBit0(DEV_ID[0]),
    .deviceIdentityBit1(DEV_ID[1]), .deviceIdentityBit2(DEV_ID[2]), .link(mqps_if_i.dev));
  mqps_host mqps_host_i (.clk(clk), .rst_n(rst_n), .link(mqps_if_i.host),
    .userWrSelect(userWrSelect), .userWrSelAddr(userWrSelAddr), .userWrValid(userWrValid),
    .userWrData(userWrData), .userAfSelect(userAfSelect), .userRdSelect(userRdSelect),
    .userRdSelAddr(userRdSelAddr), .userRdNull(userRdNull), .userAeSelect(userAeSelect),
    .userFlagDevice(userFlagDevice), .userRdTake(userRdTake), .userOutEnable(userOutEnable),
    .userWrSelReady(userWrSelReady), .userRdSelReady(userRdSelReady),
    .userRdData(userRdData), .userRdDataValid(userRdDataValid), .userFull(userFull),
    .userAlmostFull(userAlmostFull), .userAlmostEmpty(userAlmostEmpty));
  mqps_sva #(.DEV_ID(DEV_ID)) mqps_sva_i (.clk(clk), .rst_n(rst_n),
    .writeQueueAddress(mqps_if_i.writeQueueAddress),
    .writeAddressStrobe(mqps_if_i.writeAddressStrobe),
    .almostFullBusStrobe(mqps_if_i.almostFullBusStrobe),
    .readQueueAddress(mqps_if_i.readQueueAddress),
    .readAddressStrobe(mqps_if_i.readAddressStrobe),
    .almostEmptyBusStrobe(mqps_if_i.almostEmptyBusStrobe),
    .nullSelect(mqps_if_i.nullSelect), .outputEnable_n(mqps_if_i.outputEnable_n),
    .dataOutEn(mqps_if_i.dataOutEn), .outputValid_n(mqps_if_i.outputValid_n),
    .activeFullEn(mqps_if_i.activeFullEn), .almostFullEn(mqps_if_i.almostFullEn),
    .almostEmptyEn(mqps_if_i.almostEmptyEn));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Words collected from the read side, plus hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (userRdDataValid === 1'b1) got.push_back(userRdData);
    if (cycles == 5000) begin
      errCount++;
      tally_and_finish();
    end
  end

  function automatic void put(input logic own, input int q, input mqps_word_t w);
    if (own && expQ[q].size() < QDEPTH) expQ[q].push_back(w);
  endfunction : put

  // Select a write queue, writing two lead words plus n more
  task automatic wr_sel(input mqps_addr_t a, input int n);
    int k;
    logic own;
    mqps_word_t w;
    own = (a[4:2] == DEV_ID);
    k = 0;
    while (userWrSelReady !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    userWrSelect <= 1'b1;
    userWrSelAddr <= a;
    for (k = 0; k < n + 2; k++) begin
      w = mqps_word_t'($random(seed));
      userWrValid <= 1'b1;
      userWrData <= w;
      if (k < 2) put(wrOwn, wrQ, w);
      else put(own, int'(a[1:0]), w);
      @(posedge clk);
      userWrSelect <= 1'b0;
    end
    userWrValid <= 1'b0;
    wrOwn = own;
    wrQ = int'(a[1:0]);
    repeat (5) @(posedge clk);
    `CHK(userFull, own && expQ[wrQ].size() == QDEPTH)
  endtask : wr_sel

  task automatic flag_chk(input mqps_id_t d);
    mqps_flags_t af;
    mqps_flags_t ae;
    for (int q = 0; q < NUM_Q; q++) begin
      af[q] = (d == DEV_ID) && expQ[q].size() >= int'(AF_LEVEL);
      ae[q] = (d == DEV_ID) && expQ[q].size() <= int'(AE_LEVEL);
    end
    userFlagDevice <= d;
    userAfSelect <= 1'b1;
    userAeSelect <= 1'b1;
    @(posedge clk);
    userAfSelect <= 1'b0;
    userAeSelect <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(userAlmostFull, af)
    `CHK(userAlmostEmpty, ae)
  endtask : flag_chk

  // Select a read queue and wait until its words have arrived
  task automatic rd_sel(input mqps_addr_t a, input logic nul);
    int k;
    k = 0;
    while (userRdSelReady !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    userRdSelect <= 1'b1;
    userRdSelAddr <= a;
    userRdNull <= nul;
    @(posedge clk);
    userRdSelect <= 1'b0;
    userRdNull <= 1'b0;
    if (!nul && a[4:2] == DEV_ID) begin
      while (expQ[a[1:0]].size() > 0) expStream.push_back(expQ[a[1:0]].pop_front());
    end
    k = 0;
    while (got.size() < expStream.size() && k < 60) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
  endtask : rd_sel

  initial begin
    rst_n = 1'b0;
    seed = 32'h464b;
    {userWrSelect, userWrValid, userAfSelect, userRdSelect, userRdNull, userAeSelect} = '0;
    userRdTake = 1'b1;
    userOutEnable = 1'b1;
    userWrSelAddr = '0;
    userRdSelAddr = '0;
    userWrData = '0;
    userFlagDevice = '0;
    {errCount, checked, cycles, wrQ} = '0;
    wrOwn = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr_sel({DEV_ID, 2'h0}, 8);
    wr_sel({DEV_ID, 2'h1}, 10);
    wr_sel({DEV_ID ^ 3'h1, 2'h2}, 3);
    wr_sel({DEV_ID, 2'h2}, 1 + ($random(seed) & 7));
    wr_sel({DEV_ID, 2'h3}, $random(seed) & 3);
    wr_sel({DEV_ID, 2'h0}, 2);
    flag_chk(DEV_ID);
    flag_chk(DEV_ID + 3'h1);
    rd_sel({DEV_ID, 2'h3}, 1'b0);
    rd_sel({DEV_ID, 2'h0}, 1'b0);
    rd_sel({DEV_ID, 2'h2}, 1'b0);
    rd_sel({DEV_ID, 2'h1}, 1'b0);
    `CHK(got.size(), expStream.size())
    foreach (expStream[i]) `CHK(got[i], expStream[i])
    rd_sel({DEV_ID ^ 3'h2, 2'h1}, 1'b0);
    rd_sel(5'h00, 1'b1);
    `CHK(mqps_if_i.outputValid_n, 1'b1)
    `CHK(mqps_if_i.dataBus, expStream[expStream.size()-1])
    userOutEnable <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(mqps_if_i.dataBus, '0)
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
